//--- logic/ccp_pkg.sv
// constants of the codec control port register bank
package ccp_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [6:0] OFS_RSVD = 7'h00;
  localparam logic [6:0] OFS_ADC = 7'h01;
  localparam logic [6:0] OFS_DAC = 7'h02;
  localparam logic [6:0] OFS_ATTL = 7'h03;
  localparam logic [6:0] OFS_ATTR = 7'h04;
  localparam logic [6:0] OFS_PORT = 7'h05;
  localparam logic [6:0] OFS_STAT = 7'h06;
  localparam logic [6:0] OFS_CLK = 7'h07;
  // ********************
  // reset values and write masks
  // ********************
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_ADC = 8'h00;
  localparam logic [7:0] RST_DAC = 8'h00;
  localparam logic [7:0] RST_ATT = 8'h00;
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [7:0] RST_CLK = 8'h00;
  localparam logic [7:0] ADC_WMASK = 8'hfc;
  localparam logic [7:0] DAC_WMASK = 8'h7b;
  localparam logic [7:0] PORT_WMASK = 8'h7f;
  localparam logic [7:0] CLK_WMASK = 8'h03;
  // ********************
  // field positions
  // ********************
  localparam int PTR_POINTER_AUTO_ADVANCE = 7;
  localparam int ADC_PDN = 7;
  localparam int ADC_HPL = 5;
  localparam int ADC_MUL = 3;
  localparam int ADC_CAL = 2;
  localparam int ADC_BUSY = 1;
  localparam int DAC_ZMUTE = 6;
  localparam int DAC_DAC_SILENCE_LEFT = 4;
  localparam int DAC_SOFT = 3;
  localparam int DAC_RMP = 0;
  localparam int PORT_DEM = 5;
  localparam int PORT_BIT_EDGE_POLARITY = 4;
  localparam int PORT_DOF = 2;
  localparam int PORT_DIF = 0;
  localparam int CLK_MCK = 0;
  // ********************
  // link addresses
  // ********************
  localparam logic [6:0] SPI_ADDR = 7'h10;
  localparam logic [5:0] I2C_ADDR_HI = 6'h08;
  // ********************
  // timing and levels
  // ********************
  localparam int CLK_MHZ = 100;
  localparam int CAL_MS = 50;
  localparam int CAL_CYC = CAL_MS * 1000 * CLK_MHZ;
  localparam int MCLK_STOP_US = 10;
  localparam logic [9:0] MCLK_STOP_CYC = 10'(MCLK_STOP_US * CLK_MHZ);
  localparam logic [9:0] ZERO_RUN = 10'h200;
  localparam logic [7:0] ATT_MAX = 8'he3;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [5:0] STEP_C0 = 6'h08;
  localparam logic [5:0] STEP_C1 = 6'h04;
  localparam logic [5:0] STEP_C2 = 6'h10;
  localparam logic [5:0] STEP_C3 = 6'h20;
endpackage

//--- logic/ccp_sync.sv
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ns
module ccp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins in, clean levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge clk) begin
      if (srst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        s1 <= d[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          q[i] <= s3;
        end
      end
    end
  end
endmodule

//--- logic/ccp_regs.sv
// control port and configuration register bank of the stereo codec
`timescale 1ns/1ns
// Functional notes
// - spi: inputs only, data taken rising edge
// - spi: pointer byte, then data bytes stored
// - no register read path over spi
// - pointer bit 7 selects auto advance
// - i2c: address 001000 plus pin, r/w bit
// - i2c: pointer byte, read returns, acks
// - status and busy/fault bits read only
// - reset restores defaults, then calibration runs
// - cal rising edge starts calibration, busy flag
// - clock stop or bad ratio powers down
// - high-pass bypass and adc mute bits
// - zero-run mute and per-channel dac mute
// - ramp select: ramp or zero crossing
// - step rate codes give 8/4/16/32 frames
// - attenuation above 227 mutes the dac
// - de-emphasis curve select field
// - audio bit-clock edge polarity bit
// - input and output frame format fields
// - volume pending until setting accepted
// - sticky peak level cleared on read
// - master clock ratio field in register 7
module ccp_regs #(
  parameter int CAL_CYCLES = ccp_pkg::CAL_CYC
) (
  // clocks and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ctrl_serial_clock,
  // control port pins
  input wire logic spi_mode_select,
  input wire logic address_lsb_pin,
  input wire logic ctrl_serial_in,
  output logic ctrl_sda_out,
  output logic ctrl_sda_oe,
  // audio clocks
  input wire logic master_clock_in,
  input wire logic frame_sync_clock,
  // converter status in
  input wire logic dac_sample_strobe,
  input wire logic dac_zero_left,
  input wire logic dac_zero_right,
  input wire logic volume_accept_left,
  input wire logic volume_accept_right,
  input wire logic [2:0] adc_level_left,
  input wire logic [2:0] adc_level_right,
  // adc and chip controls
  output logic power_down,
  output logic offset_trim_busy,
  output logic clocking_fault,
  output logic highpass_bypass_left,
  output logic highpass_bypass_right,
  output logic adc_out_mute_left,
  output logic adc_out_mute_right,
  // dac controls
  output logic dac_out_muted_left,
  output logic dac_out_muted_right,
  output logic zero_cross_mode,
  output logic [5:0] volume_step_frames,
  output logic [7:0] level_cut_left,
  output logic [7:0] level_cut_right,
  // audio port controls
  output logic [1:0] tone_curve_select,
  output logic bit_edge_polarity,
  output logic [1:0] out_frame_format,
  output logic [1:0] in_frame_format,
  output logic [1:0] master_ratio_select
);
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_MACK} ccp_i2c_t;

  logic [7:0] ptr_reg;
  logic [7:0] rsvd_reg;
  logic [7:0] adc_reg;
  logic [7:0] dac_reg;
  logic [7:0] att_reg [2];
  logic [7:0] port_reg;
  logic [7:0] clk_reg;
  logic busy_reg;
  logic fault_reg;
  logic pdn_reg;
  logic sda_out_reg;
  logic sda_oe_reg;
  logic [5:0] step_reg;
  logic [1:0] mute_reg;
  logic [1:0] pend_reg;
  logic [2:0] peak_reg [2];
  logic [2:0] lvl_in [2];
  logic [1:0] zero_v;
  logic [1:0] acc_v;
  logic [7:0] rd_data;
  logic [7:0] ev_byte;
  logic wr_ev;
  logic ptr_ev;
  logic rd_ev;
  logic stat_rd;

  // ********************
  // spi link side
  // ********************
  logic spi_fend;
  logic l_rst;
  logic srst_hold_reg;
  logic [2:0] l_cnt;
  logic [1:0] l_phase;
  logic [6:0] l_sh;
  logic [7:0] l_in;
  logic [7:0] l_byte;
  logic l_ok;
  logic l_tog;
  logic l_isptr;
  assign l_in = {l_sh, ctrl_serial_in};
  assign spi_fend = address_lsb_pin | ~spi_mode_select;
  assign l_rst = srst_hold_reg | ~spi_mode_select;

  always_ff @(posedge clk) begin
    srst_hold_reg <= srst;
  end

  always_ff @(posedge ctrl_serial_clock or posedge spi_fend) begin
    if (spi_fend) begin
      l_cnt <= 3'h0;
      l_phase <= 2'h0;
      l_sh <= 7'h00;
      l_ok <= 1'b0;
    end else begin
      l_sh <= l_in[6:0];
      l_cnt <= l_cnt + 3'h1;
      if (l_cnt == 3'h7) begin
        if (l_phase == 2'h0) begin
          l_ok <= (l_in == {ccp_pkg::SPI_ADDR, 1'b0});
        end
        if (l_phase != 2'h2) begin
          l_phase <= l_phase + 2'h1;
        end
      end
    end
  end

  // completed bytes held stable and flagged by a toggle
  always_ff @(posedge ctrl_serial_clock or posedge l_rst) begin
    if (l_rst) begin
      l_tog <= 1'b0;
      l_byte <= 8'h00;
      l_isptr <= 1'b0;
    end else if (!spi_fend && l_cnt == 3'h7 && l_phase != 2'h0 && l_ok) begin
      l_byte <= l_in;
      l_isptr <= (l_phase == 2'h1);
      l_tog <= ~l_tog;
    end
  end

  // ********************
  // pin synchronisers
  // ********************
  logic scl_q, sda_q, adp_q, mck_q, lrk_q, tog_q;
  logic scl_p, sda_p, mck_p, lrk_p, tog_p;
  logic scl_r, scl_f, i_start, i_stop, spi_ev;

  ccp_sync #(.W(6)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({ctrl_serial_clock, ctrl_serial_in, address_lsb_pin, master_clock_in, frame_sync_clock, l_tog}),
    .q({scl_q, sda_q, adp_q, mck_q, lrk_q, tog_q})
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      {scl_p, sda_p, mck_p, lrk_p, tog_p} <= 5'h00;
    end else begin
      {scl_p, sda_p, mck_p, lrk_p, tog_p} <= {scl_q, sda_q, mck_q, lrk_q, tog_q};
    end
  end

  assign scl_r = scl_q & ~scl_p;
  assign scl_f = ~scl_q & scl_p;
  assign i_start = ~spi_mode_select & scl_q & scl_p & sda_p & ~sda_q;
  assign i_stop = scl_q & scl_p & ~sda_p & sda_q;
  assign spi_ev = tog_q ^ tog_p;

  // ********************
  // i2c engine
  // ********************
  ccp_i2c_t st;
  logic [3:0] i_cnt;
  logic [7:0] i_sh;
  logic [1:0] i_phase;
  logic i_rd;

  always_ff @(posedge clk) begin
    if (srst || spi_mode_select) begin
      st <= I_IDLE;
      i_cnt <= 4'h0;
      i_sh <= 8'h00;
      i_phase <= 2'h0;
      i_rd <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (i_start) begin
      st <= I_RX;
      i_cnt <= 4'h0;
      i_phase <= 2'h0;
      i_rd <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (i_stop) begin
      st <= I_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (st)
        I_IDLE: begin
        end
        I_RX: begin
          if (scl_r) begin
            i_sh <= {i_sh[6:0], sda_q};
            i_cnt <= i_cnt + 4'h1;
          end else if (scl_f && i_cnt == 4'h8) begin
            if (i_phase == 2'h0 && i_sh[7:1] != {ccp_pkg::I2C_ADDR_HI, adp_q}) begin
              st <= I_IDLE;
            end else begin
              st <= I_ACK;
              sda_oe_reg <= 1'b1;
              if (i_phase == 2'h0) begin
                i_rd <= i_sh[0];
              end
              if (i_phase != 2'h2) begin
                i_phase <= i_phase + 2'h1;
              end
            end
          end
        end
        I_ACK: begin
          if (scl_f) begin
            i_cnt <= 4'h0;
            if (i_rd) begin
              st <= I_TX;
              i_sh <= rd_data;
              sda_oe_reg <= ~rd_data[7];
            end else begin
              st <= I_RX;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        I_TX: begin
          if (scl_f) begin
            if (i_cnt == 4'h7) begin
              st <= I_MACK;
              sda_oe_reg <= 1'b0;
            end else begin
              i_cnt <= i_cnt + 4'h1;
              i_sh <= {i_sh[6:0], 1'b0};
              sda_oe_reg <= ~i_sh[6];
            end
          end
        end
        I_MACK: begin
          if (scl_r && sda_q) begin
            st <= I_IDLE;
          end else if (scl_f) begin
            st <= I_TX;
            i_cnt <= 4'h0;
            i_sh <= rd_data;
            sda_oe_reg <= ~rd_data[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    sda_out_reg <= 1'b0;
  end

  // ********************
  // merged byte events
  // ********************
  logic i_done;
  assign i_done = (st == I_RX) && scl_f && (i_cnt == 4'h8);
  assign ev_byte = spi_ev ? l_byte : i_sh;
  assign ptr_ev = (spi_ev & l_isptr) | (i_done & (i_phase == 2'h1));
  assign wr_ev = (spi_ev & ~l_isptr) | (i_done & (i_phase == 2'h2));
  assign rd_ev = scl_f & (((st == I_ACK) & i_rd) | (st == I_MACK));
  assign stat_rd = rd_ev & (ptr_reg[6:0] == ccp_pkg::OFS_STAT);

  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_reg <= ccp_pkg::RST_PTR;
    end else if (ptr_ev) begin
      ptr_reg <= ev_byte;
    end else if ((wr_ev || rd_ev) && ptr_reg[ccp_pkg::PTR_POINTER_AUTO_ADVANCE]) begin
      ptr_reg <= {ptr_reg[7], ptr_reg[6:0] + 7'h01};
    end
  end

  // ********************
  // register writes and reads
  // ********************
  always_ff @(posedge clk) begin
    if (srst) begin
      rsvd_reg <= ccp_pkg::RST_RSVD;
      adc_reg <= ccp_pkg::RST_ADC;
      dac_reg <= ccp_pkg::RST_DAC;
      att_reg[0] <= ccp_pkg::RST_ATT;
      att_reg[1] <= ccp_pkg::RST_ATT;
      port_reg <= ccp_pkg::RST_PORT;
      clk_reg <= ccp_pkg::RST_CLK;
    end else if (wr_ev) begin
      case (ptr_reg[6:0])
        ccp_pkg::OFS_RSVD: rsvd_reg <= ev_byte;
        ccp_pkg::OFS_ADC: adc_reg <= ev_byte & ccp_pkg::ADC_WMASK;
        ccp_pkg::OFS_DAC: dac_reg <= ev_byte & ccp_pkg::DAC_WMASK;
        ccp_pkg::OFS_ATTL: att_reg[0] <= ev_byte;
        ccp_pkg::OFS_ATTR: att_reg[1] <= ev_byte;
        ccp_pkg::OFS_PORT: port_reg <= ev_byte & ccp_pkg::PORT_WMASK;
        ccp_pkg::OFS_CLK: clk_reg <= ev_byte & ccp_pkg::CLK_WMASK;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (ptr_reg[6:0])
      ccp_pkg::OFS_RSVD: rd_data = rsvd_reg;
      ccp_pkg::OFS_ADC: rd_data = {adc_reg[7:2], busy_reg, fault_reg};
      ccp_pkg::OFS_DAC: rd_data = dac_reg;
      ccp_pkg::OFS_ATTL: rd_data = att_reg[0];
      ccp_pkg::OFS_ATTR: rd_data = att_reg[1];
      ccp_pkg::OFS_PORT: rd_data = port_reg;
      ccp_pkg::OFS_STAT: rd_data = {pend_reg[1], pend_reg[0], peak_reg[1], peak_reg[0]};
      ccp_pkg::OFS_CLK: rd_data = clk_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // ********************
  // calibration
  // ********************
  logic [22:0] cal_cnt;
  logic cal_go;
  assign cal_go = wr_ev && (ptr_reg[6:0] == ccp_pkg::OFS_ADC) && ev_byte[ccp_pkg::ADC_CAL]
    && !adc_reg[ccp_pkg::ADC_CAL];

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_reg <= 1'b1;
      cal_cnt <= 23'h000000;
    end else if (cal_go) begin
      busy_reg <= 1'b1;
      cal_cnt <= 23'h000000;
    end else if (busy_reg) begin
      if (cal_cnt == 23'(CAL_CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end else begin
        cal_cnt <= cal_cnt + 23'h000001;
      end
    end
  end

  // ********************
  // clock monitor and power down
  // ********************
  logic [9:0] stop_cnt;
  logic [9:0] ratio_cnt;
  logic ratio_bad;
  logic [1:0] frame_seen_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      stop_cnt <= 10'h000;
      ratio_cnt <= 10'h000;
      ratio_bad <= 1'b0;
      frame_seen_reg <= 2'h0;
    end else begin
      if (mck_q != mck_p) begin
        stop_cnt <= 10'h000;
      end else if (stop_cnt != ccp_pkg::MCLK_STOP_CYC) begin
        stop_cnt <= stop_cnt + 10'h001;
      end
      if (lrk_q && !lrk_p) begin
        // a master clock rise in the same cycle belongs to the new frame
        ratio_cnt <= (mck_q && !mck_p) ? 10'h001 : 10'h000;
        // first two frame edges after reset may bound a partial frame
        frame_seen_reg <= {frame_seen_reg[0], 1'b1};
        ratio_bad <= frame_seen_reg[1] && (ratio_cnt != ccp_pkg::RATIO_256) && (ratio_cnt != ccp_pkg::RATIO_384)
          && (ratio_cnt != ccp_pkg::RATIO_512);
      end else if (mck_q && !mck_p && ratio_cnt != 10'h3ff) begin
        ratio_cnt <= ratio_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_reg <= 1'b0;
      pdn_reg <= 1'b1;
    end else begin
      fault_reg <= (stop_cnt == ccp_pkg::MCLK_STOP_CYC) | ratio_bad;
      pdn_reg <= adc_reg[ccp_pkg::ADC_PDN] | fault_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      step_reg <= ccp_pkg::STEP_C0;
    end else begin
      unique case (dac_reg[ccp_pkg::DAC_RMP +: 2])
        2'h0: step_reg <= ccp_pkg::STEP_C0;
        2'h1: step_reg <= ccp_pkg::STEP_C1;
        2'h2: step_reg <= ccp_pkg::STEP_C2;
        2'h3: step_reg <= ccp_pkg::STEP_C3;
      endcase
    end
  end

  // ********************
  // per-channel mute, pending and peak
  // ********************
  assign zero_v = {dac_zero_right, dac_zero_left};
  assign acc_v = {volume_accept_right, volume_accept_left};
  assign lvl_in[0] = adc_level_left;
  assign lvl_in[1] = adc_level_right;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [9:0] zrun;
    always_ff @(posedge clk) begin
      if (srst) begin
        zrun <= 10'h000;
      end else if (dac_sample_strobe) begin
        if (!zero_v[i]) begin
          zrun <= 10'h000;
        end else if (zrun != ccp_pkg::ZERO_RUN) begin
          zrun <= zrun + 10'h001;
        end
      end
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        mute_reg[i] <= 1'b0;
      end else begin
        mute_reg[i] <= dac_reg[ccp_pkg::DAC_DAC_SILENCE_LEFT + i] | (att_reg[i] > ccp_pkg::ATT_MAX)
          | (dac_reg[ccp_pkg::DAC_ZMUTE] & (zrun == ccp_pkg::ZERO_RUN));
      end
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        pend_reg[i] <= 1'b0;
      end else if (wr_ev && ptr_reg[6:0] == ccp_pkg::OFS_ATTL + 7'(i)) begin
        pend_reg[i] <= 1'b1;
      end else if (acc_v[i]) begin
        pend_reg[i] <= 1'b0;
      end
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        peak_reg[i] <= 3'h0;
      end else if (stat_rd || lvl_in[i] > peak_reg[i]) begin
        peak_reg[i] <= lvl_in[i];
      end
    end
  end

  // ********************
  // outputs
  // ********************
  assign ctrl_sda_out = sda_out_reg;
  assign ctrl_sda_oe = sda_oe_reg;
  assign power_down = pdn_reg;
  assign offset_trim_busy = busy_reg;
  assign clocking_fault = fault_reg;
  assign highpass_bypass_left = adc_reg[ccp_pkg::ADC_HPL];
  assign highpass_bypass_right = adc_reg[ccp_pkg::ADC_HPL + 1];
  assign adc_out_mute_left = adc_reg[ccp_pkg::ADC_MUL];
  assign adc_out_mute_right = adc_reg[ccp_pkg::ADC_MUL + 1];
  assign dac_out_muted_left = mute_reg[0];
  assign dac_out_muted_right = mute_reg[1];
  assign zero_cross_mode = dac_reg[ccp_pkg::DAC_SOFT];
  assign volume_step_frames = step_reg;
  assign level_cut_left = att_reg[0];
  assign level_cut_right = att_reg[1];
  assign tone_curve_select = port_reg[ccp_pkg::PORT_DEM +: 2];
  assign bit_edge_polarity = port_reg[ccp_pkg::PORT_BIT_EDGE_POLARITY];
  assign out_frame_format = port_reg[ccp_pkg::PORT_DOF +: 2];
  assign in_frame_format = port_reg[ccp_pkg::PORT_DIF +: 2];
  assign master_ratio_select = clk_reg[ccp_pkg::CLK_MCK +: 2];

  // ********************
  // checks
  // ********************
  a_cal_start: assert property (@(posedge clk) disable iff (srst) cal_go |=> busy_reg ##1 busy_reg)
    else $error("calibration did not start");
  a_busy_ro: assert property (@(posedge clk) disable iff (srst)
    (wr_ev && ptr_reg[6:0] == ccp_pkg::OFS_ADC && !cal_go && !busy_reg) |=> !busy_reg)
    else $error("busy bit changed by write");
  a_ptr_fixed: assert property (@(posedge clk) disable iff (srst)
    (wr_ev && !ptr_ev && !ptr_reg[ccp_pkg::PTR_POINTER_AUTO_ADVANCE]) |=> $stable(ptr_reg))
    else $error("pointer moved without auto advance");
  a_ptr_step: assert property (@(posedge clk) disable iff (srst)
    (wr_ev && !ptr_ev && ptr_reg[ccp_pkg::PTR_POINTER_AUTO_ADVANCE]) |=> ptr_reg[6:0] == $past(ptr_reg[6:0]) + 7'h01)
    else $error("pointer did not advance");
  a_spi_quiet: assert property (@(posedge clk) disable iff (srst)
    spi_mode_select |=> !sda_oe_reg)
    else $error("data line driven in spi mode");
  a_att_mute: assert property (@(posedge clk) disable iff (srst)
    (att_reg[0] > ccp_pkg::ATT_MAX) |=> dac_out_muted_left)
    else $error("left dac not muted above limit");
  a_step_four: assert property (@(posedge clk) disable iff (srst)
    (dac_reg[1:0] == 2'h1) |=> volume_step_frames == ccp_pkg::STEP_C1)
    else $error("step interval wrong");
  a_peak_clear: assert property (@(posedge clk) disable iff (srst)
    stat_rd |=> peak_reg[0] == $past(adc_level_left))
    else $error("peak not cleared by read");
  a_pdn_set: assert property (@(posedge clk) disable iff (srst)
    adc_reg[ccp_pkg::ADC_PDN] [*2] |-> power_down)
    else $error("power down not applied");
  a_undef_ignored: assert property (@(posedge clk) disable iff (srst)
    (wr_ev && ptr_reg[6:3] != 4'h0) |=> $stable(adc_reg) && $stable(dac_reg) && $stable(port_reg))
    else $error("undefined write changed state");
endmodule

//--- test/ccp_host.sv
// host model driving the control port as spi writer or i2c master
`timescale 1ns/1ns
module ccp_host (
  // bus lines
  output logic scl,
  output logic sdo,
  output logic cs_n,
  // resolved data line
  input wire logic sda
);
  initial begin
    scl = 1'b0;
    sdo = 1'b1;
    cs_n = 1'b1;
  end
  // ********************
  // spi frames
  // ********************
  task automatic idle(input logic i2c);
    scl = i2c;
    sdo = 1'b1;
    cs_n = 1'b1;
  endtask
  task automatic spi_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdo = b[i];
      #15 scl = 1'b1;
      #15 scl = 1'b0;
    end
    #90;
  endtask
  task automatic spi_frame(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    cs_n = 1'b0;
    #30;
    spi_byte(a);
    spi_byte(p);
    spi_byte(d0);
    spi_byte(d1);
    cs_n = 1'b1;
    sdo = ~sdo;
    #200;
  endtask
  // ********************
  // i2c transfers
  // ********************
  task automatic start;
    sdo = 1'b1;
    #250 scl = 1'b1;
    #250 sdo = 1'b0;
    #250 scl = 1'b0;
    #250;
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    sdo = b;
    #250 scl = 1'b1;
    #250 r = sda;
    #250 scl = 1'b0;
    #250;
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i], r[i]);
    i2c_bit(1'b1, ak);
  endtask
  task automatic i2c_xfer(input logic [6:0] a, input logic [7:0] p, input logic wr, input logic [7:0] d,
                          output logic [7:0] r, output logic ak);
    logic [7:0] x;
    logic k0, k1, k2;
    start;
    i2c_byte({a, 1'b0}, x, k0);
    i2c_byte(p, x, k1);
    if (wr)
      i2c_byte(d, x, k2);
    else begin
      start;
      i2c_byte({a, 1'b1}, x, k2);
      i2c_byte(8'hff, r, x[0]);
    end
    sdo = 1'b0;
    #250 scl = 1'b1;
    #250 sdo = 1'b1;
    #500;
    ak = k0 | k1 | k2;
  endtask
endmodule

//--- test/ccp_regs_bench.sv
// self-checking bench of the control port register bank
`timescale 1ns/1ns
module ccp_regs_bench;
  logic clk = 1'b0, srst = 1'b1, mode = 1'b1, mclk = 1'b0, mrun = 1'b1, acc_l = 1'b0, oe_seen = 1'b0;
  logic [7:0] mcnt = 8'h00;
  logic [2:0] lv_l = 3'h0, lv_r = 3'h0;
  logic scl, sdo, cs_n, oe, sda_o, pd, busy, fault, hp_l, hp_r, am_l, am_r, dm_l, dm_r, zc, pol, ak;
  logic [5:0] stepf;
  logic [7:0] cut_l, cut_r, rd;
  logic [1:0] tone, ofmt, ifmt, ratio;
  logic [7:0] steps [4] = '{8'h08, 8'h04, 8'h10, 8'h20};
  int err_count = 0, checks = 0;
  wire sda = oe ? 1'b0 : sdo;
  always #5 clk = ~clk;
  always #40 if (mrun) mclk = ~mclk;
  always @(posedge mclk) mcnt <= mcnt + 8'h01;
  always @(posedge clk) if (mode && oe === 1'b1) oe_seen <= 1'b1;
  ccp_host i_ccp_host (.scl(scl), .sdo(sdo), .cs_n(cs_n), .sda(sda));
  ccp_regs #(.CAL_CYCLES(200)) i_ccp_regs (
    .clk(clk), .srst(srst), .ctrl_serial_clock(scl), .spi_mode_select(mode),
    .address_lsb_pin(mode ? cs_n : 1'b1), .ctrl_serial_in(sda), .ctrl_sda_out(sda_o), .ctrl_sda_oe(oe),
    .master_clock_in(mclk), .frame_sync_clock(mcnt[7]), .dac_sample_strobe(1'b0), .dac_zero_left(1'b0),
    .dac_zero_right(1'b0), .volume_accept_left(acc_l), .volume_accept_right(1'b0), .adc_level_left(lv_l),
    .adc_level_right(lv_r), .power_down(pd), .offset_trim_busy(busy), .clocking_fault(fault),
    .highpass_bypass_left(hp_l), .highpass_bypass_right(hp_r), .adc_out_mute_left(am_l),
    .adc_out_mute_right(am_r), .dac_out_muted_left(dm_l), .dac_out_muted_right(dm_r), .zero_cross_mode(zc),
    .volume_step_frames(stepf), .level_cut_left(cut_l), .level_cut_right(cut_r), .tone_curve_select(tone),
    .bit_edge_polarity(pol), .out_frame_format(ofmt), .in_frame_format(ifmt), .master_ratio_select(ratio));
  // ********************
  // shared tasks
  // ********************
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_on(input bit sel, input logic v, input int n);
    int i;
    for (i = 0; i < n && (sel ? fault : busy) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == n) begin
      err_count++;
      $display("Error wait expected %h", v);
      stop_test;
    end
  endtask
  task automatic do_reset(input logic m);
    @(posedge clk) #1 srst = 1'b1;
    mode = m;
    i_ccp_host.idle(!m);
    repeat (8) @(posedge clk);
    check("pd", pd, 1'b1);
    check("cut_l", cut_l, 8'h00);
    #1 srst = 1'b0;
    @(posedge clk);
    #1 check("busy", busy, 1'b1);
    wait_on(1'b0, 1'b0, 400);
    repeat (8) @(posedge clk);
  endtask
  // ********************
  // test sequence
  // ********************
  initial begin
    do_reset(1'b1);
    i_ccp_host.spi_frame(8'h20, 8'h83, 8'ha5, 8'he3);
    check("cut_l", cut_l, 8'ha5);
    check("cut_r", cut_r, 8'he3);
    check("dm_r", dm_r, 1'b0);
    i_ccp_host.spi_frame(8'h20, 8'h04, 8'he4, 8'he4);
    check("dm_r", dm_r, 1'b1);
    i_ccp_host.spi_frame(8'h20, 8'h05, 8'h7f, 8'h35);
    check("port", {1'b0, tone, pol, ofmt, ifmt}, 8'h35);
    i_ccp_host.spi_frame(8'h21, 8'h03, 8'h00, 8'h00);
    i_ccp_host.spi_frame(8'h20, 8'h09, 8'h00, 8'h00);
    check("cut", {cut_l[3:0], cut_r[3:0]}, 8'h54);
    foreach (steps[k]) begin
      i_ccp_host.spi_frame(8'h20, 8'h02, 8'h08 | 8'(k), 8'h08 | 8'(k));
      check("step", {2'b00, stepf}, steps[k]);
      check("zc", zc, 1'b1);
    end
    i_ccp_host.spi_frame(8'h20, 8'h02, 8'h10, 8'h10);
    check("dac", {zc, dm_l}, 8'h01);
    i_ccp_host.spi_frame(8'h20, 8'h01, 8'h7b, 8'h7b);
    check("adc", {pd, hp_r, hp_l, am_r, am_l, busy}, 8'h1e);
    i_ccp_host.spi_frame(8'h20, 8'h01, 8'h04, 8'h04);
    check("busy", busy, 1'b1);
    wait_on(1'b0, 1'b0, 400);
    i_ccp_host.spi_frame(8'h20, 8'h01, 8'h80, 8'h80);
    check("pd", pd, 1'b1);
    check("oe", oe_seen, 1'b0);
    $display("test spi done");
    do_reset(1'b0);
    lv_l = 3'h6;
    lv_r = 3'h5;
    i_ccp_host.i2c_xfer(7'h11, 8'h87, 1'b1, 8'h02, rd, ak);
    check("ack", ak, 1'b0);
    check("sda_o", sda_o, 1'b0);
    check("ratio", ratio, 2'h2);
    i_ccp_host.i2c_xfer(7'h11, 8'h03, 1'b1, 8'h10, rd, ak);
    lv_l = 3'h2;
    lv_r = 3'h1;
    i_ccp_host.i2c_xfer(7'h11, 8'h06, 1'b0, 8'h00, rd, ak);
    check("stat", rd, 8'h6e);
    @(posedge clk) #1 acc_l = 1'b1;
    @(posedge clk) #1 acc_l = 1'b0;
    i_ccp_host.i2c_xfer(7'h11, 8'h06, 1'b0, 8'h00, rd, ak);
    check("stat", rd, 8'h0a);
    i_ccp_host.i2c_xfer(7'h10, 8'h03, 1'b1, 8'h00, rd, ak);
    check("nack", ak, 1'b1);
    mrun = 1'b0;
    wait_on(1'b1, 1'b1, 1500);
    repeat (2) @(posedge clk);
    #1 check("pd", pd, 1'b1);
    check("cut_l", cut_l, 8'h10);
    i_ccp_host.i2c_xfer(7'h11, 8'h01, 1'b1, 8'hff, rd, ak);
    i_ccp_host.i2c_xfer(7'h11, 8'h01, 1'b0, 8'h00, rd, ak);
    check("adc", rd, 8'hfd);
    $display("test i2c done");
    stop_test;
  end
endmodule
